// ===== logic/sacs_defines.svh
// Register offsets, field positions, reset values and timing counts of the ADC sequencer.
// Summary of operation
// RQ1 - Conversion lasts at least eighteen ADC clocks.
// RQ2 - Sample aperture length is software programmable.
// RQ3 - Eight fixed input channels, selected to converter.
// RQ4 - Scan steps enabled channels without idle cycles.
// RQ5 - Firmware or state machine drives channel switching.
// RQ6 - Each channel keeps its own result store.
// RQ7 - Each channel has its own sample time.
// RQ8 - Out-of-range result flags interrupt immediately.
// RQ9 - Sequencer held inactive in deepest sleep.
// RQ10 - Scan wraps to first channel, signals done.
`ifndef SACS_DEFINES_SVH
`define SACS_DEFINES_SVH

`define SACS_OFS_CTRL       8'h00
`define SACS_OFS_CHEN       8'h04
`define SACS_OFS_APERT      8'h08
`define SACS_OFS_LIMIT      8'h0c
`define SACS_OFS_STATUS     8'h10
`define SACS_OFS_FIFO       8'h14
`define SACS_OFS_SMPT_BASE  8'h20
`define SACS_OFS_RES_BASE   8'h40
`define SACS_OFS_RES_END    8'h5c

`define SACS_CTRL_SCAN_EN   0
`define SACS_CTRL_FW_MODE   1
`define SACS_CTRL_FW_START  2
`define SACS_CTRL_FW_CH_LO  4
`define SACS_STAT_BUSY      0
`define SACS_STAT_DONE      1
`define SACS_STAT_OOR       2
`define SACS_STAT_CH_LO     4
`define SACS_STAT_CNT_LO    8
`define SACS_LIM_HIGH_LO    16
`define SACS_FIFO_VALID     15

`define SACS_RST_CTRL       8'h00
`define SACS_RST_CHEN       8'h01
`define SACS_RST_APERT      8'h04
`define SACS_RST_LOW        12'h000
`define SACS_RST_HIGH       12'hfff
`define SACS_RST_SMPT       8'h00

`define SACS_PCLK_MHZ       25
`define SACS_ADC_CLOCKS     18
`define SACS_ADC_MAX_MHZ    18
`define SACS_CONV_TIME_NS   ((`SACS_ADC_CLOCKS * 1000) / `SACS_ADC_MAX_MHZ)
`define SACS_CONV_CYCLES    ((`SACS_CONV_TIME_NS * `SACS_PCLK_MHZ + 999) / 1000)

`endif

// ===== logic/sacs_pkg.sv
// Types shared by the ADC sequencer files.
package sacs_pkg;
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_SAMPLE, SEQ_CONVERT} sacs_state_t;
endpackage

// ===== logic/sacs_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/100ps
`default_nettype none
module sacs_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8,
    localparam int AW   = $clog2(DEPTH)
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic      [AW:0]      count
);
    // Pointers wrap naturally, so DEPTH must be a power of two.
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [WIDTH-1:0] mem_next [DEPTH];
    logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
    logic [AW:0]      cnt_reg, cnt_next;
    logic             push, pop;

    assign in_ready  = cnt_reg != (AW+1)'(DEPTH);
    assign out_valid = cnt_reg != '0;
    assign out_data  = mem_reg[rd_reg];
    assign count     = cnt_reg;
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb begin
        mem_next = mem_reg;
        wr_next  = wr_reg;
        rd_next  = rd_reg;
        cnt_next = cnt_reg;
        if (push) begin
            mem_next[wr_reg] = in_data;
            wr_next          = wr_reg + 1'b1;
        end
        if (pop) begin
            rd_next = rd_reg + 1'b1;
        end
        if (push && !pop) begin
            cnt_next = cnt_reg + 1'b1;
        end else if (pop && !push) begin
            cnt_next = cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_reg <= '{default: '0};
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            mem_reg <= mem_next;
            wr_reg  <= wr_next;
            rd_reg  <= rd_next;
            cnt_reg <= cnt_next;
        end
    end
endmodule
`default_nettype wire

// ===== logic/sacs_result_mem.sv
// Per-channel result store with one write port and a registered read port.
`timescale 1ns/100ps
`default_nettype none
module sacs_result_mem #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8,
    localparam int AW   = $clog2(DEPTH)
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             we,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic [AW-1:0]    raddr,
    output logic      [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [WIDTH-1:0] mem_next [DEPTH];

    always_comb begin
        mem_next = mem_reg;
        if (we) begin
            mem_next[waddr] = wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_reg <= '{default: '0};
            rdata   <= '0;
        end else begin
            mem_reg <= mem_next;
            rdata   <= mem_reg[raddr];
        end
    end
endmodule
`default_nettype wire

// ===== logic/sacs_sequencer.sv
// Top of the SAR ADC channel sequencer with its APB register file.
`timescale 1ns/100ps
`default_nettype none
`include "sacs_defines.svh"
module sacs_sequencer #(
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [11:0] adc_result,
    input  wire logic        deep_sleep,
    output logic             adc_sample,
    output logic             adc_start,
    output logic      [2:0]  adc_mux_sel,
    output logic             range_irq,
    output logic             scan_done
);
    import sacs_pkg::*;

    localparam logic [7:0] CONV_CYCLES = 8'(`SACS_CONV_CYCLES);
    localparam int         CW          = $clog2(FIFO_DEPTH) + 1;

    // Next enabled channel after cur, wrapping round all eight.
    function automatic logic [2:0] next_en(input logic [2:0] cur, input logic [7:0] en);
        logic [2:0] res;
        logic [2:0] k;
        res = cur;
        for (int i = 8; i >= 1; i--) begin
            k = cur + 3'(i);
            if (en[k]) begin
                res = k;
            end
        end
        return res;
    endfunction

    // A zero per-channel time falls back to the global aperture.
    function automatic logic [7:0] smp_cycles(input logic [7:0] own, input logic [7:0] glob);
        logic [7:0] v;
        v = (own != 8'h00) ? own : glob;
        return (v == 8'h00) ? 8'h01 : v;
    endfunction

    logic [7:0]  ctrl_reg, ctrl_next;
    logic [7:0]  chen_reg, chen_next;
    logic [7:0]  apert_reg, apert_next;
    logic [11:0] low_reg, low_next, high_reg, high_next;
    logic [7:0]  smpt_reg [8];
    logic [7:0]  smpt_next [8];
    logic        done_reg, done_next, oor_reg, oor_next;
    logic [31:0] prdata_next;
    logic        pready_next, pslverr_next, irq_next;

    sacs_state_t st_reg, st_next;
    logic [2:0]  ch_reg, ch_next;
    logic [7:0]  cnt_reg, cnt_next;
    logic        smp_next, start_next, sdone_next;

    logic        acc_first, wr_done, rd_done, addr_ok, fw_start;
    logic        conv_fin, out_rng, wrap, go_on;
    logic [2:0]  nxt_ch;
    logic [11:0] mem_rdata;
    logic        f_in_ready, f_out_valid;
    logic [15:0] f_out_data;
    logic [CW-1:0] f_count;

    assign acc_first = psel & penable & ~pready;
    assign wr_done   = psel & penable & pready & pwrite;
    assign rd_done   = psel & penable & pready & ~pwrite;
    assign addr_ok   = (paddr[1:0] == 2'b00) &&
                       ((paddr <= `SACS_OFS_FIFO) ||
                        ((paddr >= `SACS_OFS_SMPT_BASE) && (paddr <= `SACS_OFS_RES_END)));
    assign fw_start  = wr_done && (paddr == `SACS_OFS_CTRL) && pwdata[`SACS_CTRL_FW_START];

    // A conversion finishes only when the FIFO can take its result.
    assign conv_fin = (st_reg == SEQ_CONVERT) && (cnt_reg == 8'h01) && f_in_ready && !deep_sleep;
    assign out_rng  = (adc_result < low_reg) || (adc_result > high_reg);
    assign nxt_ch   = next_en(ch_reg, chen_reg);
    assign wrap     = nxt_ch <= ch_reg;
    assign go_on    = !ctrl_reg[`SACS_CTRL_FW_MODE] && ctrl_reg[`SACS_CTRL_SCAN_EN] &&
                      (chen_reg != 8'h00);

    sacs_result_mem #(.WIDTH(12), .DEPTH(8)) u_mem (
        .pclk    (pclk),
        .presetn (presetn),
        .we      (conv_fin), // RQ6
        .waddr   (ch_reg),
        .wdata   (adc_result),
        .raddr   (paddr[4:2]),
        .rdata   (mem_rdata)
    );

    sacs_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (conv_fin),
        .in_ready  (f_in_ready),
        .in_data   ({1'b0, ch_reg, adc_result}),
        .out_valid (f_out_valid),
        .out_ready (rd_done && (paddr == `SACS_OFS_FIFO)),
        .out_data  (f_out_data),
        .count     (f_count)
    );

    // Register file and APB answer; every access takes two access cycles.
    always_comb begin
        ctrl_next    = ctrl_reg;
        chen_next    = chen_reg;
        apert_next   = apert_reg;
        low_next     = low_reg;
        high_next    = high_reg;
        smpt_next    = smpt_reg;
        prdata_next  = prdata;
        pslverr_next = 1'b0;
        pready_next  = acc_first;
        if (acc_first) begin
            pslverr_next = !addr_ok;
            prdata_next  = 32'h0000_0000;
            case (paddr)
                `SACS_OFS_CTRL:   prdata_next[7:0] = ctrl_reg;
                `SACS_OFS_CHEN:   prdata_next[7:0] = chen_reg;
                `SACS_OFS_APERT:  prdata_next[7:0] = apert_reg;
                `SACS_OFS_LIMIT:  prdata_next = {4'h0, high_reg, 4'h0, low_reg};
                `SACS_OFS_STATUS: begin
                    prdata_next[`SACS_STAT_BUSY] = st_reg != SEQ_IDLE;
                    prdata_next[`SACS_STAT_DONE] = done_reg;
                    prdata_next[`SACS_STAT_OOR]  = oor_reg;
                    prdata_next[`SACS_STAT_CH_LO +: 3] = ch_reg;
                    prdata_next[`SACS_STAT_CNT_LO +: CW] = f_count;
                end
                `SACS_OFS_FIFO: begin
                    prdata_next[15:0] = f_out_valid ? f_out_data : 16'h0000;
                    prdata_next[`SACS_FIFO_VALID] = f_out_valid;
                end
                default: begin
                    if (addr_ok && paddr >= `SACS_OFS_RES_BASE) begin
                        prdata_next[11:0] = mem_rdata; // RQ6
                    end else if (addr_ok && paddr >= `SACS_OFS_SMPT_BASE) begin
                        prdata_next[7:0] = smpt_reg[paddr[4:2]];
                    end
                end
            endcase
        end
        if (wr_done) begin
            case (paddr)
                `SACS_OFS_CTRL: begin
                    ctrl_next = pwdata[7:0];
                    ctrl_next[`SACS_CTRL_FW_START] = 1'b0;
                end
                `SACS_OFS_CHEN:  chen_next  = pwdata[7:0];
                `SACS_OFS_APERT: apert_next = pwdata[7:0]; // RQ2
                `SACS_OFS_LIMIT: begin
                    low_next  = pwdata[11:0];
                    high_next = pwdata[`SACS_LIM_HIGH_LO +: 12];
                end
                default: begin
                    if (addr_ok && paddr >= `SACS_OFS_SMPT_BASE &&
                        paddr < `SACS_OFS_RES_BASE) begin
                        smpt_next[paddr[4:2]] = pwdata[7:0]; // RQ7
                    end
                end
            endcase
        end
        // Status flags clear on a write of one; a new event in the same cycle wins.
        done_next = done_reg;
        oor_next  = oor_reg;
        if (wr_done && paddr == `SACS_OFS_STATUS) begin
            done_next = done_reg & ~pwdata[`SACS_STAT_DONE];
            oor_next  = oor_reg & ~pwdata[`SACS_STAT_OOR];
        end
        if (sdone_next) begin
            done_next = 1'b1;
        end
        if (conv_fin && out_rng) begin
            oor_next = 1'b1; // RQ8
        end
        irq_next = oor_next;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg  <= `SACS_RST_CTRL;
            chen_reg  <= `SACS_RST_CHEN;
            apert_reg <= `SACS_RST_APERT;
            low_reg   <= `SACS_RST_LOW;
            high_reg  <= `SACS_RST_HIGH;
            smpt_reg  <= '{default: `SACS_RST_SMPT};
            done_reg  <= 1'b0;
            oor_reg   <= 1'b0;
            prdata    <= 32'h0000_0000;
            pready    <= 1'b0;
            pslverr   <= 1'b0;
            range_irq <= 1'b0;
        end else begin
            ctrl_reg  <= ctrl_next;
            chen_reg  <= chen_next;
            apert_reg <= apert_next;
            low_reg   <= low_next;
            high_reg  <= high_next;
            smpt_reg  <= smpt_next;
            done_reg  <= done_next;
            oor_reg   <= oor_next;
            prdata    <= prdata_next;
            pready    <= pready_next;
            pslverr   <= pslverr_next;
            range_irq <= irq_next;
        end
    end

    // Sequencer: sample for the channel's aperture, then convert for the fixed time and until the FIFO has room.
    always_comb begin
        st_next    = st_reg;
        ch_next    = ch_reg;
        cnt_next   = cnt_reg;
        sdone_next = 1'b0;
        case (st_reg)
            SEQ_IDLE: begin
                if (fw_start && pwdata[`SACS_CTRL_FW_MODE]) begin
                    ch_next  = pwdata[`SACS_CTRL_FW_CH_LO +: 3]; // RQ5
                    st_next  = SEQ_SAMPLE;
                    cnt_next = smp_cycles(smpt_reg[ch_next], apert_reg);
                end else if (go_on) begin
                    ch_next  = next_en(3'h7, chen_reg); // RQ3
                    st_next  = SEQ_SAMPLE;
                    cnt_next = smp_cycles(smpt_reg[ch_next], apert_reg); // RQ7
                end
            end
            SEQ_SAMPLE: begin
                if (cnt_reg <= 8'h01) begin
                    st_next  = SEQ_CONVERT;
                    cnt_next = CONV_CYCLES; // RQ1
                end else begin
                    cnt_next = cnt_reg - 8'h01; // RQ2
                end
            end
            SEQ_CONVERT: begin
                if (conv_fin) begin
                    if (go_on) begin
                        ch_next    = nxt_ch; // RQ4
                        st_next    = SEQ_SAMPLE;
                        cnt_next   = smp_cycles(smpt_reg[nxt_ch], apert_reg);
                        sdone_next = wrap; // RQ10
                    end else begin
                        st_next = SEQ_IDLE;
                    end
                end else if (cnt_reg > 8'h01) begin
                    cnt_next = cnt_reg - 8'h01;
                end
            end
            default: st_next = SEQ_IDLE;
        endcase
        if (deep_sleep) begin
            st_next    = SEQ_IDLE; // RQ9
            sdone_next = 1'b0;
        end
        smp_next   = st_next == SEQ_SAMPLE;
        start_next = (st_next == SEQ_CONVERT) && (st_reg != SEQ_CONVERT);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg     <= SEQ_IDLE;
            ch_reg     <= 3'h0;
            cnt_reg    <= 8'h00;
            adc_sample <= 1'b0;
            adc_start  <= 1'b0;
            scan_done  <= 1'b0;
        end else begin
            st_reg     <= st_next;
            ch_reg     <= ch_next;
            cnt_reg    <= cnt_next;
            adc_sample <= smp_next;
            adc_start  <= start_next;
            scan_done  <= sdone_next;
        end
    end

    assign adc_mux_sel = ch_reg;

    // Helper counters that only the checks read.
    logic [7:0] conv_age, samp_age;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_age <= 8'h00;
            samp_age <= 8'h00;
        end else begin
            conv_age <= (st_reg == SEQ_CONVERT && st_next == SEQ_CONVERT) ?
                        conv_age + 8'h01 : 8'h00;
            samp_age <= (st_reg == SEQ_SAMPLE && st_next == SEQ_SAMPLE) ? samp_age + 8'h01 : 8'h00;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    conv_length_a: assert property (conv_fin |-> conv_age >= CONV_CYCLES - 8'h01) // RQ1
        else $error("conversion ended early");
    aperture_length_a: assert property (st_reg == SEQ_SAMPLE && st_next == SEQ_CONVERT
        |-> samp_age + 8'h01 == smp_cycles(smpt_reg[ch_reg], apert_reg)) // RQ7
        else $error("sample window length wrong");
    aperture_start_a: assert property ($rose(adc_start)
        |-> $past(adc_sample) && !adc_sample) // RQ2
        else $error("conversion started without sampling");
    mux_stable_a: assert property (st_reg != SEQ_IDLE && st_next != SEQ_IDLE && !conv_fin
        |=> $stable(adc_mux_sel)) // RQ3
        else $error("channel changed mid conversion");
    no_idle_a: assert property (conv_fin && go_on |=> st_reg == SEQ_SAMPLE ##0 adc_sample) // RQ4
        else $error("idle cycle between channels");
    fw_select_a: assert property (st_reg == SEQ_IDLE && fw_start && pwdata[1] && !deep_sleep
        |=> adc_mux_sel == $past(pwdata[6:4]) ##0 adc_sample) // RQ5
        else $error("firmware channel not applied");
    result_push_a: assert property (conv_fin |=> f_count != '0) // RQ6
        else $error("result not buffered");
    range_flag_a: assert property (conv_fin && out_rng |=> range_irq && oor_reg) // RQ8
        else $error("out of range not flagged");
    sleep_idle_a: assert property (deep_sleep |=> st_reg == SEQ_IDLE && !adc_sample) // RQ9
        else $error("active in deep sleep");
    wrap_done_a: assert property (conv_fin && go_on && wrap && !deep_sleep
        |=> scan_done && adc_mux_sel == next_en(3'h7, $past(chen_reg))) // RQ10
        else $error("scan wrap not signalled");

    scan_wrap_c: cover property (scan_done ##[1:200] scan_done);
    oor_event_c: cover property (conv_fin && out_rng);
    fw_conv_c: cover property (fw_start ##[1:100] conv_fin);
    fifo_stall_c: cover property (st_reg == SEQ_CONVERT && cnt_reg == 8'h01 && !f_in_ready);
endmodule
`default_nettype wire

// ===== testbench/sacs_adc_model.sv
// Behavioural model of the converter core behind the eight channel pins.
`timescale 1ns/100ps
`default_nettype none
module sacs_adc_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        adc_sample,
    input  wire logic        adc_start,
    input  wire logic [2:0]  adc_mux_sel,
    input  wire logic [11:0] base,
    output logic      [11:0] adc_result
);
    logic        conv_reg;
    logic [11:0] last_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_reg <= 1'b0;
            last_reg <= 12'h000;
        end else begin
            if (adc_start) begin
                conv_reg <= 1'b1;
            end else if (adc_sample) begin
                conv_reg <= 1'b0;
            end
            last_reg <= adc_result;
        end
    end

    // The result depends on the routed channel, so a wrong mux setting shows in the data.
    // While sampling the output is not held and toggles every cycle; after a conversion it holds until the next sample.
    assign adc_result = conv_reg ? base + {1'b0, adc_mux_sel, 8'h00} : ~last_reg;
endmodule
`default_nettype wire

// ===== testbench/tb.sv
// Self-checking testbench of the ADC channel sequencer.
`timescale 1ns/100ps
`default_nettype none
`include "sacs_defines.svh"
module tb;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [11:0] adc_result;
    logic        deep_sleep;
    logic        adc_sample;
    logic        adc_start;
    logic [2:0]  adc_mux_sel;
    logic        range_irq;
    logic        scan_done;
    logic [11:0] base;
    logic        err_seen;
    int          num_errors;
    int          tests_run;

    sacs_sequencer #(.FIFO_DEPTH(8)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .adc_result(adc_result), .deep_sleep(deep_sleep), .adc_sample(adc_sample),
        .adc_start(adc_start), .adc_mux_sel(adc_mux_sel), .range_irq(range_irq),
        .scan_done(scan_done));

    sacs_adc_model adc (
        .pclk(pclk), .presetn(presetn), .adc_sample(adc_sample), .adc_start(adc_start),
        .adc_mux_sel(adc_mux_sel), .base(base), .adc_result(adc_result));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        err_seen = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        chk(nm, exp, r);
    endtask

    function automatic logic [11:0] val(input logic [2:0] ch);
        return base + {1'b0, ch, 8'h00};
    endfunction

    task automatic pop_chk(input logic [2:0] ch);
        rd(`SACS_OFS_FIFO, {16'h0, 1'b1, ch, val(ch)}, "fifo_word");
    endtask

    // Waits for a sample window, then checks its channel, length and the start pulse.
    task automatic window(input int len, input logic [2:0] ch, input logic dn);
        int n;
        n = 0;
        while (adc_sample !== 1'b1 && n < 100) begin
            @(posedge pclk);
            n++;
        end
        chk("mux", ch, adc_mux_sel);
        chk("scan_done", dn, scan_done);
        n = 0;
        while (adc_sample === 1'b1 && n < 300) begin
            @(posedge pclk);
            n++;
        end
        chk("sample_len", len, n);
        chk("adc_start", 1'b1, adc_start);
    endtask

    task automatic fw_conv(input logic [2:0] ch, input int len);
        wr(`SACS_OFS_CTRL, {25'h0, ch, 4'h6});
        window(len, ch, 1'b0);
        repeat (26) @(posedge pclk);
    endtask

    task automatic t_reset;
        rd(`SACS_OFS_CTRL, 32'h0, "ctrl");
        rd(`SACS_OFS_CHEN, 32'h1, "chen");
        rd(`SACS_OFS_APERT, 32'h4, "apert");
        rd(`SACS_OFS_LIMIT, 32'h0fff0000, "limit");
        rd(`SACS_OFS_SMPT_BASE, 32'h0, "smpt0");
        rd(8'h18, 32'h0, "unmapped");
        chk("pslverr", 1'b1, err_seen);
        rd(8'h05, 32'h0, "misaligned");
        chk("pslverr", 1'b1, err_seen);
        $display("test reset done");
    endtask

    task automatic t_fw;
        wr(`SACS_OFS_SMPT_BASE + 8'h14, 32'h3);
        fw_conv(3'h5, 3);
        rd(`SACS_OFS_CTRL, 32'h52, "ctrl");
        rd(`SACS_OFS_RES_BASE + 8'h14, {20'h0, val(3'h5)}, "result5");
        pop_chk(3'h5);
        rd(`SACS_OFS_FIFO, 32'h0, "fifo_empty");
        $display("test firmware done");
    endtask

    task automatic t_scan;
        logic [31:0] r;
        int          n;
        wr(`SACS_OFS_CHEN, 32'h0a);
        wr(`SACS_OFS_APERT, 32'h2);
        wr(`SACS_OFS_CTRL, 32'h1);
        for (int i = 0; i < 3; i++) begin
            window(2, (i == 1) ? 3'h3 : 3'h1, i == 2);
            n = 0;
            while (adc_sample !== 1'b1 && n < 100) begin
                @(posedge pclk);
                n++;
            end
            chk("gap", 25, n);
        end
        wr(`SACS_OFS_CTRL, 32'h0);
        repeat (40) @(posedge pclk);
        chk("stopped", 1'b0, adc_sample);
        apb(1'b0, `SACS_OFS_STATUS, 32'h0, r);
        chk("status", 32'h0402, r & 32'h0f03);
        rd(`SACS_OFS_RES_BASE + 8'h0c, {20'h0, val(3'h3)}, "result3");
        for (int i = 0; i < 4; i++) pop_chk(i[0] ? 3'h3 : 3'h1);
        $display("test scan done");
    endtask

    task automatic t_range;
        logic [31:0] r;
        int          n;
        wr(`SACS_OFS_LIMIT, 32'h02000100);
        fw_conv(3'h1, 2);
        chk("range_irq", 1'b0, range_irq);
        wr(`SACS_OFS_CTRL, 32'h26);
        window(2, 3'h2, 1'b0);
        n = 0;
        while (range_irq !== 1'b1 && n < 40) begin
            @(posedge pclk);
            n++;
        end
        chk("irq_delay", 1'b1, n >= 24 && n <= 26);
        apb(1'b0, `SACS_OFS_STATUS, 32'h0, r);
        chk("flags", 32'h6, r & 32'h6);
        wr(`SACS_OFS_STATUS, 32'h6);
        apb(1'b0, `SACS_OFS_STATUS, 32'h0, r);
        chk("flags_clear", 32'h0, r & 32'h6);
        chk("range_irq", 1'b0, range_irq);
        pop_chk(3'h1);
        pop_chk(3'h2);
        wr(`SACS_OFS_LIMIT, 32'h0fff0000);
        $display("test range done");
    endtask

    task automatic t_fill;
        logic [31:0] r;
        wr(`SACS_OFS_APERT, 32'h0);
        for (int i = 0; i < 8; i++) fw_conv(i[2:0], (i == 5) ? 3 : 1);
        wr(`SACS_OFS_CTRL, 32'h06);
        window(1, 3'h0, 1'b0);
        repeat (40) @(posedge pclk);
        apb(1'b0, `SACS_OFS_STATUS, 32'h0, r);
        chk("stall", 32'h0801, r & 32'h0f01);
        pop_chk(3'h0);
        repeat (4) @(posedge pclk);
        apb(1'b0, `SACS_OFS_STATUS, 32'h0, r);
        chk("resume", 32'h0800, r & 32'h0f01);
        for (int i = 1; i < 9; i++) pop_chk(i[2:0]);
        rd(`SACS_OFS_FIFO, 32'h0, "fifo_empty");
        $display("test fill done");
    endtask

    task automatic t_sleep;
        int n;
        wr(`SACS_OFS_SMPT_BASE + 8'h08, 32'h8);
        deep_sleep <= 1'b1;
        wr(`SACS_OFS_CTRL, 32'h26);
        repeat (5) @(posedge pclk);
        chk("sleep_idle", 1'b0, adc_sample);
        deep_sleep <= 1'b0;
        wr(`SACS_OFS_CTRL, 32'h26);
        n = 0;
        while (adc_sample !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        chk("sleep_wake", 1'b1, adc_sample);
        deep_sleep <= 1'b1;
        repeat (2) @(posedge pclk);
        chk("sleep_abort", 1'b0, adc_sample);
        deep_sleep <= 1'b0;
        repeat (30) @(posedge pclk);
        rd(`SACS_OFS_FIFO, 32'h0, "fifo_dropped");
        $display("test sleep done");
    endtask

    initial begin
        presetn    = 1'b0;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = 8'h00;
        pwdata     = 32'h0;
        deep_sleep = 1'b0;
        base       = 12'h0a5;
        err_seen   = 1'b0;
        num_errors = 0;
        tests_run  = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_fw;
        t_scan;
        t_range;
        t_fill;
        t_sleep;
        end_of_test;
    end

    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        end_of_test;
    end
endmodule
`default_nettype wire
